//--- rss_pkg.sv
package rss_pkg;

  localparam int TMR_W = 28;
  localparam int CLK_MHZ = 250;

  // Times as printed, in their own units.
  localparam int WAKE_US = 150;
  localparam int LIGHT_MS = 200;
  localparam int PAUSE_S = 1;
  localparam int AVG_SHORT_MS = 2;
  localparam int AVG_LONG_MS = 50;
  localparam int BOOT_NS = 2000;

  // Cycle counts derived from the clock rate.
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int LIGHT_CYC = LIGHT_MS * 1000 * CLK_MHZ;
  localparam int PAUSE_CYC = PAUSE_S * 1000000 * CLK_MHZ;
  localparam int AVG_SHORT_CYC = AVG_SHORT_MS * 1000 * CLK_MHZ;
  localparam int AVG_LONG_CYC = AVG_LONG_MS * 1000 * CLK_MHZ;
  localparam int BOOT_CYC = (BOOT_NS * CLK_MHZ + 999) / 1000;

  // Register map, byte addresses.
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] CAUSE_ADDR = 8'h08;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_EXTB_BIT = 1;
  localparam int CTRL_RESTART_BIT = 2;
  localparam logic CTRL_AUTO_RST = 1'b1;
  localparam logic CTRL_EXTB_RST = 1'b0;
  localparam int STATUS_SSDONE_BIT = 3;
  localparam int STATUS_COMP_LSB = 4;
  localparam int CAUSE_W = 9;

  typedef enum logic [2:0] {
    ST_STARTUP = 3'b000,
    ST_SWITCH_CLOSED = 3'b001,
    ST_SWITCH_OPEN = 3'b011,
    ST_WAKEUP = 3'b010,
    ST_BOOT = 3'b110,
    ST_NORMAL_RUN = 3'b111,
    ST_LIGHT_RUN = 3'b101,
    ST_FAULT = 3'b100
  } rss_state_t;

  typedef struct packed {
    logic line_unplug_detected;
    logic trim_load_done;
    logic zero_current_region;
    logic feedback_copy_below_ss;
    logic feedback_below_burst_level;
    logic line_zero_cross_seen;
    logic supply_above_start_switching;
    logic supply_below_restart;
    logic bias_reg_undervoltage;
    logic bulk_overvoltage;
    logic bulk_below_stop;
    logic bulk_above_start;
    logic avg_current_fault_long;
    logic avg_current_fault_short;
    logic peak_current_fault;
    logic output_overvoltage_fault;
    logic over_temp;
  } rss_comp_t;

  localparam int COMP_W = $bits(rss_comp_t);

  typedef struct packed {
    logic supply_thresh_ext_sel;
    logic burst_adapt_on;
    logic burst_level_from_pin;
    logic ss_replaced_by_supply;
    logic pin_pulldown_on;
    logic line_cap_discharge_on;
    logic low_side_gate_out;
    logic startup_current_high;
    logic startup_switch_on;
    logic soft_start_enable;
    logic supply_clamp_enable;
    logic bias_regulator_enable;
    logic waveform_gen_enable;
  } rss_en_t;

endpackage

//--- rss_sync.sv
`timescale 1ns/1ns
`default_nettype none
module rss_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // rss_sync
`default_nettype wire

//--- rss_timer.sv
`timescale 1ns/1ns
`default_nettype none
module rss_timer import rss_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic run,
  input wire logic [TMR_W-1:0] limit,
  output logic expired
);
  logic [TMR_W-1:0] cnt_r;

  assign expired = (cnt_r >= limit);

  // Saturates at the limit so a held condition never wraps back to idle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (clear) begin
      cnt_r <= '0;
    end else if (run && !expired) begin
      cnt_r <= cnt_r + TMR_W'(1);
    end
  end
endmodule // rss_timer
`default_nettype wire

//--- rss_sequencer.sv
// How it works
// - Soft start runs from boot end to replica crossing.
// - After soft start, supply replaces ramp; pin sets burst.
// - Zero-current region pulls shared pin down in normal and light run only.
// - Burst level tracks sensed bulk voltage.
// - Reset enters startup: clamp and start switch on.
// - Switch-closed state: only start switch, high current.
// - Supply above start level opens switch, bias on.
// - Wake-up holds 150us with bias regulator only.
// - Boot charge drives low-side gate for fixed time.
// - Run enables generator, bias, soft start.
// - Light load over 200ms is a fault.
// - Fault drops all enables but line discharge and threshold select, waits 1s to restart; code keeps the swap and burst enables on for the first two fault cycles.
// - Short average overcurrent qualified for 2ms.
// - Long average overcurrent qualified for 50ms.
// - Start level threshold differs by bias mode.
// - Fault either stops or pauses then restarts.
// - Listed fault sources all enter fault; code: only in run, else over-temp and (switch-open/wake-up) bulk overvoltage.
// - Fast faults arrive pre-handled by waveform generator.
// - Wake-up needs all four bulk/bias conditions.
// - Line capacitor discharge follows unplug detection only.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module rss_sequencer import rss_pkg::*; #(
  parameter logic [TMR_W-1:0] WAKE_CYCLES = TMR_W'(WAKE_CYC),
  parameter logic [TMR_W-1:0] LIGHT_CYCLES = TMR_W'(LIGHT_CYC),
  parameter logic [TMR_W-1:0] PAUSE_CYCLES = TMR_W'(PAUSE_CYC),
  parameter logic [TMR_W-1:0] AVG_SHORT_CYCLES = TMR_W'(AVG_SHORT_CYC),
  parameter logic [TMR_W-1:0] AVG_LONG_CYCLES = TMR_W'(AVG_LONG_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [COMP_W-1:0] comp_in,
  output rss_en_t en
);

  rss_comp_t c;
  rss_state_t state_r;
  rss_state_t state_nxt;
  rss_en_t en_nxt;
  logic [COMP_W-1:0] comp_s;
  logic auto_restart_r;
  logic ext_bias_r;
  logic restart_r;
  logic ss_done_r;
  logic [CAUSE_W-1:0] cause_r;
  logic [CAUSE_W-1:0] cause_set;
  logic [TMR_W-1:0] st_limit;
  logic st_expired;
  logic short_expired;
  logic long_expired;
  logic fault_any;
  logic wake_ok;
  logic setup;
  logic wr;
  logic mapped;

  rss_sync #(.W(COMP_W)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(comp_in),
    .q(comp_s)
  );

  assign c = rss_comp_t'(comp_s);

  rss_timer u_short (
    .clk(pclk),
    .rst_n(presetn),
    .clear(!c.avg_current_fault_short),
    .run(c.avg_current_fault_short),
    .limit(AVG_SHORT_CYCLES),
    .expired(short_expired)
  );

  rss_timer u_long (
    .clk(pclk),
    .rst_n(presetn),
    .clear(!c.avg_current_fault_long),
    .run(c.avg_current_fault_long),
    .limit(AVG_LONG_CYCLES),
    .expired(long_expired)
  );

  // One timer serves every timed state; a state change restarts it.
  always_comb begin
    case (state_r)
      ST_WAKEUP: st_limit = WAKE_CYCLES;
      ST_BOOT: st_limit = TMR_W'(BOOT_CYC);
      ST_LIGHT_RUN: st_limit = LIGHT_CYCLES;
      ST_FAULT: st_limit = PAUSE_CYCLES;
      default: st_limit = '1;
    endcase
  end

  rss_timer u_state (
    .clk(pclk),
    .rst_n(presetn),
    .clear(state_nxt != state_r),
    .run(1'b1),
    .limit(st_limit),
    .expired(st_expired)
  );

  // Overvoltage and peak current are already qualified upstream, so they act at once.
  assign fault_any = c.over_temp | c.bulk_overvoltage | c.bulk_below_stop |
                     c.output_overvoltage_fault | c.peak_current_fault |
                     short_expired | long_expired | c.bias_reg_undervoltage;

  assign wake_ok = c.bulk_above_start && !c.bulk_below_stop &&
                   !c.bulk_overvoltage && !c.bias_reg_undervoltage;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_STARTUP: begin
        if (c.over_temp) begin
          state_nxt = ST_FAULT;
        end else if (c.trim_load_done) begin
          state_nxt = ST_SWITCH_CLOSED;
        end
      end
      ST_SWITCH_CLOSED: begin
        if (c.over_temp) begin
          state_nxt = ST_FAULT;
        end else if (c.supply_above_start_switching && !c.supply_below_restart) begin
          state_nxt = ST_SWITCH_OPEN;
        end
      end
      ST_SWITCH_OPEN: begin
        if (c.over_temp || c.bulk_overvoltage) begin
          state_nxt = ST_FAULT;
        end else if (c.supply_below_restart) begin
          state_nxt = ST_SWITCH_CLOSED;
        end else if (wake_ok) begin
          state_nxt = ST_WAKEUP;
        end
      end
      ST_WAKEUP: begin
        if (c.over_temp || c.bulk_overvoltage) begin
          state_nxt = ST_FAULT;
        end else if (c.supply_below_restart) begin
          state_nxt = ST_SWITCH_CLOSED;
        end else if (st_expired) begin
          state_nxt = ST_BOOT;
        end
      end
      ST_BOOT: begin
        if (c.over_temp) begin
          state_nxt = ST_FAULT;
        end else if (c.supply_below_restart) begin
          state_nxt = ST_SWITCH_CLOSED;
        end else if (st_expired) begin
          state_nxt = ST_NORMAL_RUN;
        end
      end
      ST_NORMAL_RUN: begin
        if (fault_any) begin
          state_nxt = ST_FAULT;
        end else if (c.supply_below_restart) begin
          state_nxt = ST_SWITCH_CLOSED;
        end else if (ss_done_r && c.feedback_below_burst_level) begin
          state_nxt = ST_LIGHT_RUN;
        end
      end
      ST_LIGHT_RUN: begin
        if (fault_any || st_expired) begin
          state_nxt = ST_FAULT;
        end else if (c.supply_below_restart) begin
          state_nxt = ST_SWITCH_CLOSED;
        end else if (!c.feedback_below_burst_level) begin
          state_nxt = ST_NORMAL_RUN;
        end
      end
      ST_FAULT: begin
        // In stop mode only a software restart leaves, and never before the pause.
        if (st_expired && (auto_restart_r || restart_r)) begin
          state_nxt = ST_SWITCH_CLOSED;
        end
      end
      default: state_nxt = ST_STARTUP;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_STARTUP;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_done_r <= 1'b0;
    end else if (state_r != ST_NORMAL_RUN && state_r != ST_LIGHT_RUN) begin
      ss_done_r <= 1'b0;
    end else if (c.feedback_copy_below_ss) begin
      ss_done_r <= 1'b1;
    end
  end

  // Enables follow the next state so they line up with the state register.
  always_comb begin
    en_nxt = '0;
    case (state_nxt)
      ST_STARTUP: begin
        en_nxt.supply_clamp_enable = 1'b1;
        en_nxt.startup_switch_on = 1'b1;
      end
      ST_SWITCH_CLOSED: begin
        en_nxt.startup_switch_on = 1'b1;
        en_nxt.startup_current_high = 1'b1;
      end
      ST_SWITCH_OPEN: en_nxt.bias_regulator_enable = 1'b1;
      ST_WAKEUP: en_nxt.bias_regulator_enable = 1'b1;
      ST_BOOT: begin
        en_nxt.bias_regulator_enable = 1'b1;
        en_nxt.low_side_gate_out = 1'b1;
      end
      ST_NORMAL_RUN, ST_LIGHT_RUN: begin
        en_nxt.waveform_gen_enable = 1'b1;
        en_nxt.bias_regulator_enable = 1'b1;
        en_nxt.soft_start_enable = 1'b1;
        en_nxt.pin_pulldown_on = c.zero_current_region;
      end
      ST_FAULT: en_nxt = '0;
      default: en_nxt = '0;
    endcase
    en_nxt.ss_replaced_by_supply = ss_done_r;
    en_nxt.burst_level_from_pin = ss_done_r;
    en_nxt.burst_adapt_on = ss_done_r;
    en_nxt.supply_thresh_ext_sel = ext_bias_r;
    en_nxt.line_cap_discharge_on = c.line_unplug_detected;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en <= '0;
    end else begin
      en <= en_nxt;
    end
  end

  // Bus slave: zero wait states, read data captured in the setup cycle.
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign mapped = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR) || (paddr == CAUSE_ADDR);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_restart_r <= CTRL_AUTO_RST;
      ext_bias_r <= CTRL_EXTB_RST;
      restart_r <= 1'b0;
    end else begin
      restart_r <= 1'b0;
      if (wr && paddr == CTRL_ADDR) begin
        auto_restart_r <= pwdata[CTRL_AUTO_BIT];
        ext_bias_r <= pwdata[CTRL_EXTB_BIT];
        restart_r <= pwdata[CTRL_RESTART_BIT];
      end
    end
  end

  // Causes are caught on fault entry; a new cause beats a clear in the same cycle.
  always_comb begin
    cause_set = '0;
    if (state_nxt == ST_FAULT && state_r != ST_FAULT) begin
      cause_set = {st_expired && state_r == ST_LIGHT_RUN, c.bias_reg_undervoltage,
                   long_expired, short_expired, c.peak_current_fault,
                   c.output_overvoltage_fault, c.bulk_below_stop,
                   c.bulk_overvoltage, c.over_temp};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r <= '0;
    end else if (wr && paddr == CAUSE_ADDR) begin
      cause_r <= (cause_r & ~pwdata[CAUSE_W-1:0]) | cause_set;
    end else begin
      cause_r <= cause_r | cause_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup) begin
      case (paddr)
        CTRL_ADDR: prdata <= {30'h0, ext_bias_r, auto_restart_r};
        STATUS_ADDR: prdata <= {11'h0, comp_s, ss_done_r, state_r};
        CAUSE_ADDR: prdata <= {23'h0, cause_r};
        default: prdata <= '0;
      endcase
    end
  end

endmodule // rss_sequencer
`default_nettype wire

//--- rss_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module rss_analog_model import rss_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire rss_en_t en,
  input wire rss_comp_t cmd,
  output logic [COMP_W-1:0] comp_in
);
  // The supply climbs only while the start-up switch feeds it.
  logic [3:0] chg_r;
  rss_comp_t lvl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) chg_r <= 4'h0;
    else if (en.startup_switch_on && chg_r != 4'hf) chg_r <= chg_r + 4'h1;
  end
  always_comb begin
    lvl = cmd;
    lvl.trim_load_done = presetn;
    lvl.supply_above_start_switching = chg_r == 4'hf;
    comp_in = lvl;
  end
endmodule // rss_analog_model
`default_nettype wire

//--- rss_sequencer_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rss_sequencer_assertions import rss_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [COMP_W-1:0] comp_in,
  input wire rss_en_t en
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_startup_pattern: assert property (
    en.supply_clamp_enable |-> en.startup_switch_on && !en.bias_regulator_enable
    && !en.waveform_gen_enable && !en.soft_start_enable)
    else $error("clamp on outside start-up");
  a_run_pattern: assert property (
    en.waveform_gen_enable |-> en.bias_regulator_enable && en.soft_start_enable
    && !en.supply_clamp_enable && !en.startup_switch_on)
    else $error("bad run enables");
  a_boot_pattern: assert property (
    en.low_side_gate_out |-> en.bias_regulator_enable && !en.waveform_gen_enable
    && !en.startup_switch_on)
    else $error("bad boot enables");
  a_boot_hold: assert property (
    $rose(en.low_side_gate_out) |-> en.low_side_gate_out [*8])
    else $error("boot charge cut short");
  a_pulldown_run: assert property (
    en.pin_pulldown_on |-> en.waveform_gen_enable)
    else $error("pin pulled down outside run");
  a_supply_swap: assert property (
    $rose(en.ss_replaced_by_supply) |-> en.burst_level_from_pin && en.waveform_gen_enable)
    else $error("swap without burst level");
  a_discharge_follow: assert property (
    $rose(comp_in[16]) |-> ##[1:4] en.line_cap_discharge_on)
    else $error("discharge did not follow unplug");
  a_temp_fault: assert property (
    comp_in[0] && en.bias_regulator_enable |-> ##[1:4] !en.bias_regulator_enable)
    else $error("over-temperature ignored");
endmodule // rss_sequencer_assertions
bind rss_sequencer rss_sequencer_assertions rss_sequencer_assertions_i (.pclk, .presetn,
  .comp_in, .en);
`default_nettype wire

//--- resonant_supply_state_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
module resonant_supply_state_sequencer_test import rss_pkg::*;;
  localparam int WK = 20, LT = 40, PS = 30, AS = 10, AL = 15;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic [COMP_W-1:0] comp_in;
  rss_comp_t c = '0;
  rss_en_t en;
  int fails = 0, comparisons = 0, n;
  always #2 pclk = ~pclk;
  rss_sequencer #(.WAKE_CYCLES(TMR_W'(WK)), .LIGHT_CYCLES(TMR_W'(LT)),
    .PAUSE_CYCLES(TMR_W'(PS)), .AVG_SHORT_CYCLES(TMR_W'(AS)), .AVG_LONG_CYCLES(TMR_W'(AL)))
    rss_sequencer_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .comp_in, .en);
  rss_analog_model rss_analog_model_i (.pclk, .presetn, .en, .cmd(c), .comp_in);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task ok(input logic b);
    chk(32'(b), 32'h1);
  endtask
  task ck_en(input logic [5:0] e);
    chk(32'({en[6], en[4:0]}), 32'(e));
  endtask
  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts are judged in a window because the input synchroniser adds edges.
  task wait_en(input int b, input logic v);
    n = 0;
    while (en[b] !== v && n < 2000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task final_report;
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task t_start;
    ck_en(6'h14);
    cyc(4);
    ck_en(6'h10);
    ok(en.startup_current_high);
    cyc(20);
    ck_en(6'h02);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h1);
    chk(32'(er), 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    ok(er);
  endtask
  task t_wake;
    c.bulk_above_start <= 1'b1;
    c.bias_reg_undervoltage <= 1'b1;
    cyc(8);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(32'(rd[2:0]), 32'(ST_SWITCH_OPEN));
    c.bias_reg_undervoltage <= 1'b0;
    wait_en(6, 1'b1);
    ok(n >= WK && n <= WK + 6);
    wait_en(6, 1'b0);
    ok(n >= BOOT_CYC - 1 && n <= BOOT_CYC + 1);
    cyc(1);
    ck_en(6'h0b);
    ok(!en.ss_replaced_by_supply);
  endtask
  task t_soft;
    c.feedback_copy_below_ss <= 1'b1;
    cyc(5);
    chk(32'(en[11:9]), 32'h7);
    apb(1'b0, STATUS_ADDR, 32'h0);
    ok(rd[STATUS_SSDONE_BIT]);
    c.zero_current_region <= 1'b1;
    cyc(5);
    ok(en.pin_pulldown_on);
    c.zero_current_region <= 1'b0;
  endtask
  task automatic t_faults;
    int src[9] = '{0, 1, 2, 6, 7, 8, 3, 4, 12};
    int cb[9] = '{0, 3, 4, 2, 1, 7, 5, 6, 8};
    int lim[9] = '{0, 0, 0, 0, 0, 0, AS, AL, LT};
    for (int i = 0; i < 9; i++) begin
      if (lim[i] > 0) begin
        c[src[i]] <= 1'b1;
        cyc(lim[i] - 3);
        c[src[i]] <= 1'b0;
        cyc(6);
        ok(en.waveform_gen_enable);
      end
      c[src[i]] <= 1'b1;
      wait_en(0, 1'b0);
      ok(n <= lim[i] + 8 && n + 2 >= lim[i]);
      cyc(1);
      ck_en(6'h00);
      c[src[i]] <= 1'b0;
      wait_en(1, 1'b1);
      ok(n >= PS - 3 && n <= PS + 6);
      apb(1'b0, CAUSE_ADDR, 32'h0);
      chk(rd, 32'h1 << cb[i]);
      apb(1'b1, CAUSE_ADDR, 32'h1ff);
      wait_en(0, 1'b1);
      ok(n < 700);
    end
  endtask
  task t_stop;
    apb(1'b1, CTRL_ADDR, 32'h0);
    c.over_temp <= 1'b1;
    cyc(6);
    c.over_temp <= 1'b0;
    c.line_unplug_detected <= 1'b1;
    cyc(PS + 10);
    ck_en(6'h00);
    ok(en.line_cap_discharge_on);
    c.line_unplug_detected <= 1'b0;
    apb(1'b1, CTRL_ADDR, 32'h6);
    wait_en(1, 1'b1);
    ok(n < 10);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h2);
    ok(en.supply_thresh_ext_sel);
    // A sagging supply must fall back to the closed start switch and wait there.
    c.supply_below_restart <= 1'b1;
    cyc(4);
    ck_en(6'h10);
    c.supply_below_restart <= 1'b0;
    wait_en(1, 1'b1);
    ok(n < 10);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    t_start;
    t_wake;
    t_soft;
    t_faults;
    t_stop;
    final_report;
  end
  initial begin
    #200000;
    fails++;
    final_report;
  end
endmodule // resonant_supply_state_sequencer_test
`default_nettype wire
